/* eca_cfg.svh */
// Constants for the error code annunciator: register offsets, codes, levels, timing.
// Assumes inclusion by bare name from the package and the modules.
`ifndef ECA_CFG_SVH
`define ECA_CFG_SVH
// Register byte offsets
`define ECA_CTRL_OFS        12'h000
`define ECA_STAT_OFS        12'h004
`define ECA_IRQ_OFS         12'h008
`define ECA_MASK_OFS        12'h00c
// Control bit positions
`define ECA_CTRL_CLEAR_BIT  0
// Error codes, three decimal digits held as binary
`define ECA_CODE_NONE       10'h000
`define ECA_CODE_104        10'd104
`define ECA_CODE_105        10'd105
`define ECA_CODE_106        10'd106
`define ECA_CODE_302        10'd302
`define ECA_CODE_303        10'd303
`define ECA_CODE_111        10'd111
`define ECA_CODE_112        10'd112
`define ECA_CODE_113        10'd113
`define ECA_CODE_114        10'd114
`define ECA_CODE_115        10'd115
`define ECA_CODE_116        10'd116
// Analog levels in millivolts
`define ECA_MV_FULL         14'd10000
`define ECA_MV_5V33         14'd5330
`define ECA_MV_6V66         14'd6660
`define ECA_MV_7V33         14'd7330
`define ECA_MV_8V00         14'd8000
`define ECA_MV_8V66         14'd8660
// Blink timing: 1 Hz full period, each half 500 ms
`define ECA_CLK_HZ          25000000
`define ECA_BLINK_HZ        1
`define ECA_HALF_CYCLES     (`ECA_CLK_HZ / (2 * `ECA_BLINK_HZ))
// Reset values
`define ECA_MASK_RST        2'h3
`endif

/* eca_pkg.sv */
// Types shared by the annunciator modules.
// Assumes eca_cfg.svh is on the include path.
`include "eca_cfg.svh"
package eca_pkg;
	// Annunciation state
	typedef enum logic [1:0] {
		ECA_IDLE  = 2'b00,
		ECA_WARN  = 2'b01,
		ECA_FAULT = 2'b10
	} eca_state_t;
	typedef logic [9:0]  eca_code_t;
	typedef logic [13:0] eca_mv_t;
endpackage

/* eca_lvl_if.sv */
// Interface carrying an error code to the level lookup and the level back.
// Assumes both ends run in the same clock domain.
`timescale 1ns/1ps
interface eca_lvl_if;
	import eca_pkg::*;
	eca_code_t code;   // Code to look up
	eca_mv_t   level;  // Error level in millivolts
	logic      known;  // Code has a level
	modport req (output code, input level, known);
	modport rsp (input code, output level, known);
endinterface

/* eca_level_map.sv */
// Combinational map from error code to analog error level.
// Assumes the caller registers the result.
`timescale 1ns/1ps
`include "eca_cfg.svh"
module eca_level_map
	import eca_pkg::*;
(
	eca_lvl_if.rsp lk
);
	// Lookup of code to level
	always_comb begin
		lk.level = 14'h0000;
		lk.known = 1'b1;
		case (lk.code)
			`ECA_CODE_104, `ECA_CODE_105, `ECA_CODE_106,
			`ECA_CODE_302, `ECA_CODE_303: lk.level = `ECA_MV_5V33;
			`ECA_CODE_111: lk.level = `ECA_MV_6V66;
			`ECA_CODE_112: lk.level = `ECA_MV_7V33;
			`ECA_CODE_113: lk.level = `ECA_MV_8V00;
			`ECA_CODE_114: lk.level = `ECA_MV_8V00;
			`ECA_CODE_115, `ECA_CODE_116: lk.level = `ECA_MV_8V66;
			default: lk.known = 1'b0;
		endcase
	end
endmodule

/* eca_top.sv */
// Error code annunciator: holds a warning-class code, escalates it on start,
// drives alarm LED, alarm relay and the analog level; APB registers.
// Assumes start and error reports come from same-clock logic; the clear
// request may come from a pin and is synchronised here.
`timescale 1ns/1ps
`include "eca_cfg.svh"
module eca_top
	import eca_pkg::*;
#(
	parameter int HALF_CYCLES = `ECA_HALF_CYCLES
)(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        start,
	input  wire logic        err_valid,
	input  wire logic [9:0]  err_code,
	input  wire logic        error_clear_request,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [13:0] analog_mv,
	output logic             alarm_led,
	output logic             alarm_relay,
	output logic      [9:0]  active_code,
	output logic             irq
);
	eca_state_t  state;       // Annunciation state
	eca_code_t   code;        // Held error code
	eca_mv_t     level;       // Held error level
	logic [24:0] blink_cnt;   // Half period counter
	logic        blink;       // Blink phase, high shows full scale
	logic        clr_s1;      // Pin synchroniser stage one
	logic        clr_s2;      // Pin synchroniser stage two
	logic        clr_pin_d;   // Delayed synchronised pin
	logic        sw_clr;      // Software clear bit
	logic        sw_clr_d;    // Delayed software clear bit
	logic [1:0]  irq_stat;    // Sticky events: 0 warning, 1 fault
	logic [1:0]  irq_mask;    // Interrupt enables
	logic        clr_fall;    // Clear request released
	logic        apb_wr;      // Write access strobe
	logic        set_warn;    // New warning accepted
	logic        set_fault;   // Escalation now
	logic [31:0] next_prdata; // Read mux

	eca_lvl_if lk();

	eca_level_map u_map (
		.lk (lk)
	);

	assign lk.code = err_code;

	// Clear request from the pin; first stage only feeds the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			clr_s1    <= 1'b0;
			clr_s2    <= 1'b0;
			clr_pin_d <= 1'b0;
			sw_clr_d  <= 1'b0;
		end else begin
			clr_s1    <= error_clear_request;
			clr_s2    <= clr_s1;
			clr_pin_d <= clr_s2;
			sw_clr_d  <= sw_clr;
		end
	end

	// act on the falling edge of either clear source
	assign clr_fall = (clr_pin_d & ~clr_s2) | (sw_clr_d & ~sw_clr);
	assign set_warn = err_valid & lk.known & (state == ECA_IDLE) & ~clr_fall;
	assign set_fault = (state == ECA_WARN) & start & ~clr_fall;
	assign apb_wr = psel & penable & pwrite;

	// Annunciation state machine
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= ECA_IDLE;
			code  <= `ECA_CODE_NONE;
			level <= 14'h0000;
		end else begin
			case (state)
				ECA_IDLE: begin
					if (set_warn) begin
						state <= ECA_WARN;
						code  <= err_code;
						level <= lk.level;
					end
				end
				ECA_WARN: begin
					// clear only on release of the request
					if (clr_fall) begin
						state <= ECA_IDLE;
						code  <= `ECA_CODE_NONE;
						level <= 14'h0000;
					// start turns the warning into a fault
					end else if (start) begin
						state <= ECA_FAULT;
					end
				end
				ECA_FAULT: begin
					// fault leaves only through a released clear
					if (clr_fall) begin
						state <= ECA_IDLE;
						code  <= `ECA_CODE_NONE;
						level <= 14'h0000;
					end
				end
				default: state <= ECA_IDLE;
			endcase
		end
	end

	// half period counter for 1 Hz alternation
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			blink_cnt <= 25'h0000000;
			blink     <= 1'b0;
		end else if (state != ECA_WARN) begin
			// Restart phase so every warning opens on the error level
			blink_cnt <= 25'h0000000;
			blink     <= 1'b0;
		end else if (blink_cnt == 25'(HALF_CYCLES - 1)) begin
			blink_cnt <= 25'h0000000;
			blink     <= ~blink;
		end else begin
			blink_cnt <= blink_cnt + 25'h0000001;
		end
	end

	// Output drivers, all registered
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			analog_mv   <= 14'h0000;
			alarm_led   <= 1'b0;
			alarm_relay <= 1'b0;
			active_code <= 10'h000;
		end else begin
			active_code <= code;
			case (state)
				// alternate level and full scale, LED blinks, relay off
				ECA_WARN: begin
					analog_mv   <= blink ? `ECA_MV_FULL : level;
					alarm_led   <= ~blink;
					alarm_relay <= 1'b0;
				end
				// steady level, LED on, relay energised
				ECA_FAULT: begin
					analog_mv   <= level;
					alarm_led   <= 1'b1;
					alarm_relay <= 1'b1;
				end
				// Temperature display is not this block's job; idle shows zero
				default: begin
					analog_mv   <= 14'h0000;
					alarm_led   <= 1'b0;
					alarm_relay <= 1'b0;
				end
			endcase
		end
	end

	// Software control and interrupt mask registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sw_clr   <= 1'b0;
			irq_mask <= `ECA_MASK_RST;
		end else if (apb_wr & pready) begin
			if (paddr == `ECA_CTRL_OFS) begin
				sw_clr <= pwdata[`ECA_CTRL_CLEAR_BIT];
			end else if (paddr == `ECA_MASK_OFS) begin
				irq_mask <= pwdata[1:0];
			end
		end
	end

	// Sticky events; a new event wins over a clear in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_stat <= 2'b00;
		end else begin
			if (apb_wr & pready & (paddr == `ECA_IRQ_OFS)) begin
				irq_stat <= (irq_stat & ~pwdata[1:0]) | {set_fault, set_warn};
			end else begin
				irq_stat <= irq_stat | {set_fault, set_warn};
			end
		end
	end

	// Level interrupt from unmasked sticky bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat & irq_mask);
		end
	end

	// Read mux; unmapped addresses answer with an error
	always_comb begin
		next_prdata = 32'h00000000;
		if (paddr == `ECA_CTRL_OFS) begin
			next_prdata = {31'h0, sw_clr};
		end else if (paddr == `ECA_STAT_OFS) begin
			next_prdata = {20'h0, code, state};
		end else if (paddr == `ECA_IRQ_OFS) begin
			next_prdata = {30'h0, irq_stat};
		end else if (paddr == `ECA_MASK_OFS) begin
			next_prdata = {30'h0, irq_mask};
		end
	end

	// APB slave: one wait state, answer in the access phase's second cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else if (psel & penable & ~pready) begin
			pready  <= 1'b1;
			prdata  <= pwrite ? 32'h00000000 : next_prdata;
			pslverr <= (paddr != `ECA_CTRL_OFS) && (paddr != `ECA_STAT_OFS) &&
			           (paddr != `ECA_IRQ_OFS) && (paddr != `ECA_MASK_OFS);
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Held-warning sequence for the warning output
	sequence warn_held_s;
		state == ECA_WARN && !start && !clr_fall;
	endsequence

	// relay stays off throughout a warning
	warn_relay_a: assert property (@(posedge clk) disable iff (rst)
		state == ECA_WARN |=> !alarm_relay)
		else $error("relay energised during warning");

	// warning output shows level or full scale only
	warn_level_a: assert property (@(posedge clk) disable iff (rst)
		warn_held_s ##1 state == ECA_WARN |->
		(analog_mv == level || analog_mv == `ECA_MV_FULL))
		else $error("warning output not level or full scale");

	// start in warning gives a fault with relay and LED on
	fault_esc_a: assert property (@(posedge clk) disable iff (rst)
		(state == ECA_WARN && start && !clr_fall) |=> state == ECA_FAULT ##1
		(alarm_relay && alarm_led && analog_mv == level))
		else $error("escalation to fault wrong");

	lvl_533_a: assert property (@(posedge clk) disable iff (rst)
		(set_warn && (err_code == `ECA_CODE_104 || err_code == `ECA_CODE_105 ||
		err_code == `ECA_CODE_106 || err_code == `ECA_CODE_302 ||
		err_code == `ECA_CODE_303)) |=> level == `ECA_MV_5V33)
		else $error("mismatch code level wrong");

	lvl_666_a: assert property (@(posedge clk) disable iff (rst)
		(set_warn && err_code == `ECA_CODE_111) |=> level == `ECA_MV_6V66)
		else $error("code 111 level wrong");

	lvl_733_a: assert property (@(posedge clk) disable iff (rst)
		(set_warn && err_code == `ECA_CODE_112) |=> level == `ECA_MV_7V33)
		else $error("code 112 level wrong");

	// codes 113 and 114 latch 8.00 V
	lvl_800_a: assert property (@(posedge clk) disable iff (rst)
		(set_warn && (err_code == `ECA_CODE_113 || err_code == `ECA_CODE_114))
		|=> level == `ECA_MV_8V00)
		else $error("code 113/114 level wrong");

	// codes 115 and 116 latch 8.66 V
	lvl_866_a: assert property (@(posedge clk) disable iff (rst)
		(set_warn && (err_code == `ECA_CODE_115 || err_code == `ECA_CODE_116))
		|=> level == `ECA_MV_8V66)
		else $error("code 115/116 level wrong");

	// phase only toggles at the half period count
	blink_rate_a: assert property (@(posedge clk) disable iff (rst)
		(state == ECA_WARN && $past(state) == ECA_WARN && $changed(blink)) |->
		$past(blink_cnt) == 25'(HALF_CYCLES - 1))
		else $error("blink toggled off schedule");

	// clear only after the request is released; pin high holds the error
	clr_release_a: assert property (@(posedge clk) disable iff (rst)
		(state != ECA_IDLE && clr_s2 && !(sw_clr_d && !sw_clr)) |=> state != ECA_IDLE)
		else $error("cleared while request high");

	// software clear bit held high keeps the error
	sw_clr_hold_a: assert property (@(posedge clk) disable iff (rst)
		(state != ECA_IDLE && sw_clr && !(clr_pin_d && !clr_s2)) |=> state != ECA_IDLE)
		else $error("cleared while software bit high");

	code_hold_a: assert property (@(posedge clk) disable iff (rst)
		(state != ECA_IDLE && !clr_fall) |=> $stable(code))
		else $error("held code changed");
endmodule

/* eca_plc_model.sv */
// Machine controller model: drives start and the clear pin.
// Assumes the annunciator samples both on rising clk edges.
`timescale 1ns/1ps
module eca_plc_model (
	input  wire logic clk,
	output logic      start,
	output logic      error_clear_request
);
	// Idle levels from time zero
	initial begin
		start = 1'b0;
		error_clear_request = 1'b0;
	end
	task automatic press();
		@(posedge clk) start <= 1'b1;
		@(posedge clk) start <= 1'b0;
	endtask
	localparam int CAL_TEMP_MAX_C = 40; // Highest calibration temperature
	// calibration restart only at or below the limit
	function automatic logic cal_restart_ok(input int temp_c);
		return temp_c <= CAL_TEMP_MAX_C;
	endfunction
	task automatic set_clear(input logic v);
		@(posedge clk) error_clear_request <= v;
	endtask
endmodule

/* tb_top.sv */
// Self-checking bench for the error code annunciator.
// Assumes a short blink half period and the controller model.
`timescale 1ns/1ps
module tb_top;
	localparam int HC = 8;          // Short blink half period
	logic        clk, rst, err_valid, psel, penable, pwrite;
	logic        pready, pslverr, alarm_led, alarm_relay, irq;
	logic        start, error_clear_request, e;
	logic [9:0]  err_code, active_code;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [13:0] analog_mv, lv;
	int          num_errors, checks, cycles;
	// Warning codes 104..106, 302, 303, 111..116 and levels in mV
	logic [9:0]  cd [11] = '{10'h068, 10'h069, 10'h06a, 10'h12e, 10'h12f,
		10'h06f, 10'h070, 10'h071, 10'h072, 10'h073, 10'h074};
	logic [13:0] mv [11] = '{14'h14d2, 14'h14d2, 14'h14d2, 14'h14d2, 14'h14d2,
		14'h1a04, 14'h1ca2, 14'h1f40, 14'h1f40, 14'h21d4, 14'h21d4};

	eca_top #(.HALF_CYCLES(HC)) dut_u (.clk(clk), .rst(rst), .start(start),
		.err_valid(err_valid), .err_code(err_code),
		.error_clear_request(error_clear_request), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.analog_mv(analog_mv), .alarm_led(alarm_led),
		.alarm_relay(alarm_relay), .active_code(active_code), .irq(irq));
	eca_plc_model plc_u (.clk(clk), .start(start),
		.error_clear_request(error_clear_request));

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Hang guard: a stuck wait ends the run as a failure
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			results();
		end
	end
	task automatic results();
		if (num_errors == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want) begin
			num_errors++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	// Past the edge so its updates have landed
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// APB cycle: request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk) penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic report(input logic [9:0] c);
		@(posedge clk);
		err_valid <= 1'b1;
		err_code <= c;
		@(posedge clk) err_valid <= 1'b0;
	endtask

	// Main sequence
	initial begin
		{rst, err_valid, psel, penable, pwrite} = 5'h10;
		{err_code, paddr, pwdata, cycles, num_errors, checks} = '0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd, 32'h3);
		apb(1'b0, 12'h010, 32'h0);
		chk(e, 1'b1);
		// Code 101 is no warning class
		report(10'h065);
		tick(4);
		chk(active_code, 10'h000);
		apb(1'b1, 12'h00c, 32'h0);
		for (int i = 0; i < 11; i++) begin
			lv = mv[i];
			report(cd[i]);
			for (int k = 0; k < 20 && alarm_led !== 1'b1; k++) tick(1);
			tick(HC - 1);
			chk(analog_mv, lv);
			chk({alarm_relay, active_code}, {1'b0, cd[i]});
			tick(1);
			chk({alarm_led, analog_mv}, {1'b0, 14'h2710});
			tick(HC);
			chk({alarm_led, alarm_relay, analog_mv}, {2'b10, lv});
			report(cd[(i + 1) % 11]);
			tick(3);
			chk(active_code, cd[i]);
			apb(1'b0, 12'h004, 32'h0);
			chk(rd, {20'h0, cd[i], 2'h1});
			// First pass: event latched while masked
			if (i == 0) begin
				chk(irq, 1'b0);
				apb(1'b1, 12'h00c, 32'h3);
				tick(2);
			end
			chk(irq, 1'b1);
			plc_u.press();
			tick(3);
			chk({alarm_led, alarm_relay, analog_mv}, {2'b11, lv});
			tick(HC + 2);
			chk({alarm_led, alarm_relay, analog_mv}, {2'b11, lv});
			apb(1'b0, 12'h008, 32'h0);
			chk(rd, 32'h3);
			apb(1'b1, 12'h008, 32'h3);
			tick(2);
			chk(irq, 1'b0);
			// Alternate pin and register clear paths
			if (i % 2 == 0) begin
				plc_u.set_clear(1'b1);
				tick(6);
				chk(active_code, cd[i]);
				plc_u.set_clear(1'b0);
				tick(7);
			end else begin
				apb(1'b1, 12'h000, 32'h1);
				tick(4);
				chk(active_code, cd[i]);
				apb(1'b1, 12'h000, 32'h0);
				tick(4);
			end
			chk({alarm_led, alarm_relay, analog_mv, active_code}, '0);
		end
		results();
	end
endmodule
